// *** common/wwdt_pkg.sv ***
// constants and types shared by the windowed watchdog timer
package wwdt_pkg;
    localparam logic [3:0] WWDT_OFS_CTRL = 4'h0;
    localparam logic [3:0] WWDT_OFS_MODE = 4'h4;
    localparam logic [3:0] WWDT_OFS_STAT = 4'h8;
    localparam int WWDT_CNT_W = 12;
    localparam int WWDT_PRE_DIV = 128;
    localparam logic [7:0] WWDT_KEY = 8'ha5;
    localparam int WWDT_KEY_LSB = 24;
    localparam int WWDT_RESTART_BIT = 0;
    localparam int WWDT_UNF_BIT = 0;
    localparam int WWDT_ERR_BIT = 1;
    localparam logic [31:0] WWDT_MODE_RST = 32'h3fff2fff;
    localparam logic [31:0] WWDT_MODE_MASK = 32'h3fffffff;

    // field layout of the mode register, msb first
    typedef struct packed {
        logic [1:0] rsvd;
        logic idle_halt;
        logic debug_halt;
        logic [11:0] restart_window_limit;
        logic watchdog_disable;
        logic processor_only_reset;
        logic fault_reset_enable;
        logic fault_irq_enable;
        logic [11:0] counter_load_value;
    } wwdt_mode_t;

    // status flags
    typedef struct packed {
        logic window_error_flag;
        logic underflow_flag;
    } wwdt_stat_t;
endpackage

// *** core/wwdt_top.sv ***
// windowed watchdog timer: counter, prescaler, registers and fault request
`timescale 1ns/1ps
// What this block does
// - twelve-bit down counter reloaded from load value
// - counter ticks once per slow clock over 128
// - reset: load all ones, running, reset enabled
// - mode register writable once until processor reset
// - mode write reloads counter and restarts counting
// - control write needs key a5, else discarded
// - accepted restart reloads counter and clears prescaler
// - underflow sets flag, fault if reset enabled
// - restart at or below window limit accepted
// - restart above limit: error flag and fault
// - limit at or above load disables window check
// - flags raise interrupt only when irq enabled
// - status read or reset clears flags, irq, fault
// - fault reset clears processor and watchdog state
// - processor-only bit picks processor or all resets
// - debug halt stops counter in debug state
// - idle halt stops counter in idle mode
// - disable bit stops counting, clear enables it
// - mode register resets to 3fff2fff
module wwdt_top
    import wwdt_pkg::*;
(
    input wire logic i_core_clk, // core clock, 20 mhz
    input wire logic i_reset, // synchronous processor reset, active high
    input wire logic i_slow_clk, // slow clock level, sampled
    input wire logic i_debug_state, // processor in debug state, async
    input wire logic i_idle_mode, // system in idle mode, async
    input wire logic [3:0] i_addr, // register byte address
    input wire logic [31:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after read strobe
    output logic o_irq, // watchdog interrupt, level
    output logic o_fault, // fault request to reset controller, level
    output logic o_proc_only // fault asks processor reset only
);
    logic [2:0] slow_sync_q;
    logic [2:0] dbg_sync_q;
    logic [2:0] idle_sync_q;
    logic slow_lvl_q;
    logic dbg_lvl_q;
    logic idle_lvl_q;
    logic slow_primed_q;
    wwdt_mode_t mode_q;
    logic mode_locked_q;
    logic [WWDT_CNT_W-1:0] cnt_q;
    logic [$clog2(WWDT_PRE_DIV)-1:0] pre_q;
    wwdt_stat_t stat_q;
    logic fault_q;
    logic [31:0] rdata_q;
    logic slow_rise;
    logic running;
    logic tick;
    logic mode_wr;
    logic ctrl_wr;
    logic restart_ok;
    logic restart_bad;
    logic stat_rd;
    logic underflow;

    // three-stage synchronisers; only stages 1 and 2 are looked at
    always_ff @(posedge i_core_clk) begin
        slow_sync_q <= {slow_sync_q[1:0], i_slow_clk};
        dbg_sync_q <= {dbg_sync_q[1:0], i_debug_state};
        idle_sync_q <= {idle_sync_q[1:0], i_idle_mode};
    end

    // a level change counts only once two settled stages agree
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            slow_lvl_q <= 1'b0;
            dbg_lvl_q <= 1'b0;
            idle_lvl_q <= 1'b0;
            slow_primed_q <= 1'b0;
        end else begin
            if (slow_sync_q[1] == slow_sync_q[2]) slow_lvl_q <= slow_sync_q[2];
            if (dbg_sync_q[1] == dbg_sync_q[2]) dbg_lvl_q <= dbg_sync_q[2];
            if (idle_sync_q[1] == idle_sync_q[2]) idle_lvl_q <= idle_sync_q[2];
            if (slow_sync_q[1] == slow_sync_q[2]) slow_primed_q <= 1'b1;
        end
    end

    // the first settled level after reset only primes the detector, so a slow clock
    // parked high across reset does not count as a rise
    assign slow_rise = slow_primed_q && (slow_sync_q[1] == slow_sync_q[2])
        && slow_sync_q[2] && !slow_lvl_q;

    // bus decode
    assign mode_wr = i_wr && (i_addr == WWDT_OFS_MODE) && !mode_locked_q;
    assign ctrl_wr = i_wr && (i_addr == WWDT_OFS_CTRL)
        && (i_wdata[WWDT_KEY_LSB +: 8] == WWDT_KEY)
        && i_wdata[WWDT_RESTART_BIT];
    // window check; a limit at or above load covers the whole range
    assign restart_ok = ctrl_wr && (cnt_q <= mode_q.restart_window_limit);
    assign restart_bad = ctrl_wr && !restart_ok;
    assign stat_rd = i_rd && (i_addr == WWDT_OFS_STAT);

    // stopped by disable, or by halts while debug or idle is active
    assign running = !mode_q.watchdog_disable
        && !(mode_q.debug_halt && dbg_lvl_q)
        && !(mode_q.idle_halt && idle_lvl_q);
    assign tick = running && slow_rise && (pre_q == $bits(pre_q)'(WWDT_PRE_DIV - 1));
    assign underflow = tick && (cnt_q == '0);

    // mode register, write once per processor reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mode_q <= wwdt_mode_t'(WWDT_MODE_RST);
            mode_locked_q <= 1'b0;
        end else if (mode_wr) begin
            mode_q <= wwdt_mode_t'(i_wdata & WWDT_MODE_MASK);
            mode_locked_q <= 1'b1;
        end
    end

    // prescaler: cleared on any reload so a restart gets a full period
    always_ff @(posedge i_core_clk) begin
        if (i_reset || mode_wr || restart_ok) begin
            pre_q <= '0;
        end else if (running && slow_rise) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // down counter; after underflow it reloads and keeps guarding
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cnt_q <= WWDT_MODE_RST[WWDT_CNT_W-1:0];
        end else if (mode_wr) begin
            cnt_q <= i_wdata[WWDT_CNT_W-1:0];
        end else if (restart_ok || underflow) begin
            cnt_q <= mode_q.counter_load_value;
        end else if (tick) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // sticky flags: a new event in the read cycle wins over the clear
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            stat_q <= '0;
        end else begin
            stat_q.underflow_flag <= underflow || (stat_q.underflow_flag && !stat_rd);
            stat_q.window_error_flag <= restart_bad
                || (stat_q.window_error_flag && !stat_rd);
        end
    end

    // fault request, held until a status read or reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            fault_q <= 1'b0;
        end else if ((underflow && mode_q.fault_reset_enable) || restart_bad) begin
            fault_q <= 1'b1;
        end else if (stat_rd) begin
            fault_q <= 1'b0;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            case (i_addr)
                WWDT_OFS_MODE: rdata_q <= 32'(mode_q);
                WWDT_OFS_STAT: rdata_q <= {30'h0, stat_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = mode_q.fault_irq_enable && (|stat_q);
    assign o_fault = fault_q;
    assign o_proc_only = mode_q.processor_only_reset;

    a_mode_locked: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_locked_q && i_wr && (i_addr == WWDT_OFS_MODE) |=> $stable(mode_q))
        else $error("mode register changed after lock");
    a_key_reject: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_wr && (i_addr == WWDT_OFS_CTRL) && (i_wdata[WWDT_KEY_LSB +: 8] != WWDT_KEY)
        && !mode_wr && !tick |=> $stable(cnt_q))
        else $error("unkeyed control write touched counter");
    a_restart_load: assert property (@(posedge i_core_clk) disable iff (i_reset)
        restart_ok && !mode_wr |=> cnt_q == mode_q.counter_load_value && pre_q == '0)
        else $error("restart did not reload");
    a_mode_reload: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_wr |=> cnt_q == mode_q.counter_load_value)
        else $error("mode write did not reload");
    a_window_err: assert property (@(posedge i_core_clk) disable iff (i_reset)
        ctrl_wr && (cnt_q > mode_q.restart_window_limit)
        |=> stat_q.window_error_flag && o_fault)
        else $error("window error not flagged");
    a_unf_fault: assert property (@(posedge i_core_clk) disable iff (i_reset)
        underflow && mode_q.fault_reset_enable |=> stat_q.underflow_flag && o_fault)
        else $error("underflow not reported");
    a_irq_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !mode_q.fault_irq_enable |-> !o_irq)
        else $error("interrupt without enable");
    a_read_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        stat_rd && !underflow && !restart_bad |=> stat_q == '0 && !o_fault)
        else $error("status read did not clear");
    a_halt_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !running && !mode_wr && !restart_ok |=> $stable(cnt_q))
        else $error("counter moved while halted");
    a_reset_vals: assert property (@(posedge i_core_clk)
        i_reset |=> 32'(mode_q) == WWDT_MODE_RST
        && cnt_q == WWDT_MODE_RST[WWDT_CNT_W-1:0] && !o_fault)
        else $error("reset values wrong");

    // named steps of the restart and count behaviour
    sequence s_restart_in_window;
        ctrl_wr && (cnt_q <= mode_q.restart_window_limit);
    endsequence
    sequence s_restart_early;
        ctrl_wr && (cnt_q > mode_q.restart_window_limit);
    endsequence
    sequence s_count_step;
        tick && (cnt_q != '0) && !mode_wr && !restart_ok;
    endsequence
    sequence s_underflow_event;
        underflow && !mode_wr && !restart_ok;
    endsequence
    sequence s_status_clear;
        stat_rd && !underflow && !restart_bad;
    endsequence

    // a restart inside the window never raises the error flag
    a_win_accept: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_restart_in_window |=> !$rose(stat_q.window_error_flag))
        else $error("error flag on accepted restart");

    // a limit at or above load accepts every count up to load
    a_win_default: assert property (@(posedge i_core_clk) disable iff (i_reset)
        ctrl_wr && (mode_q.restart_window_limit >= mode_q.counter_load_value)
        && (cnt_q <= mode_q.counter_load_value) |-> restart_ok)
        else $error("restart refused with open window");

    // an early restart faults even while the watchdog is disabled
    a_win_early_dis: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (mode_q.watchdog_disable ##0 s_restart_early) |=> o_fault)
        else $error("disabled watchdog ignored early restart");

    // each tick above zero takes exactly one off the count
    a_count_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_count_step |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("count step wrong");

    // underflow reloads from the programmed load value
    a_unf_reload: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_underflow_event |=> cnt_q == mode_q.counter_load_value)
        else $error("no reload after underflow");

    // the prescaler wraps on the tick that moves the counter
    a_pre_wrap: assert property (@(posedge i_core_clk) disable iff (i_reset)
        tick && !mode_wr && !restart_ok |=> pre_q == '0)
        else $error("prescaler did not wrap");

    // without a slow rise the prescaler holds
    a_pre_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !slow_rise && !mode_wr && !restart_ok |=> $stable(pre_q))
        else $error("prescaler moved without slow rise");

    // one slow rise is counted once only
    a_rise_once: assert property (@(posedge i_core_clk) disable iff (i_reset)
        slow_rise |=> !slow_rise)
        else $error("slow rise counted twice");

    // underflow with reset generation off leaves the fault line low
    a_unf_no_rst: assert property (@(posedge i_core_clk) disable iff (i_reset)
        underflow && !mode_q.fault_reset_enable && !restart_bad && !o_fault |=> !o_fault)
        else $error("fault without reset enable");

    // a pending flag with the enable set shows on the interrupt
    a_irq_follow: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_q.fault_irq_enable && (stat_q != '0) |-> o_irq)
        else $error("interrupt missing");

    // underflow flag stays until a status read
    a_unf_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
        stat_q.underflow_flag && !stat_rd |=> stat_q.underflow_flag)
        else $error("underflow flag lost");

    // error flag stays until a status read
    a_err_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
        stat_q.window_error_flag && !stat_rd |=> stat_q.window_error_flag)
        else $error("error flag lost");

    // the fault request stays until a status read
    a_fault_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_fault && !stat_rd |=> o_fault)
        else $error("fault dropped early");

    // read data is zero outside the cycle after a read
    a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !i_rd |=> o_rdata == '0)
        else $error("read data without read");

    // status read returns the flags as they stood
    a_stat_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
        stat_rd |=> o_rdata == 32'($past(stat_q)))
        else $error("status read value wrong");

    // mode read returns the register as it stood
    a_mode_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_rd && (i_addr == WWDT_OFS_MODE) |=> o_rdata == 32'($past(mode_q)))
        else $error("mode read value wrong");

    // the control register is write only and reads zero
    a_ctrl_read_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_rd && (i_addr == WWDT_OFS_CTRL) |=> o_rdata == '0)
        else $error("control read not zero");

    // the reset kind changes only with the one mode write
    a_proc_stable: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !mode_wr |=> $stable(o_proc_only))
        else $error("reset kind changed");

    // an accepted mode write locks the register
    a_lock_set: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_wr |=> mode_locked_q)
        else $error("mode not locked");

    // only a processor reset unlocks the mode register
    a_lock_keep: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_locked_q |=> mode_locked_q)
        else $error("mode lock released");

    // the two top bits of the mode register stay clear
    a_rsvd_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_q.rsvd == '0)
        else $error("reserved mode bits set");

    // debug halt freezes the counter
    a_debug_stop: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_q.debug_halt && dbg_lvl_q && !mode_wr && !restart_ok |=> $stable(cnt_q))
        else $error("counter ran in debug halt");

    // idle halt freezes the counter
    a_idle_stop: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_q.idle_halt && idle_lvl_q && !mode_wr && !restart_ok |=> $stable(cnt_q))
        else $error("counter ran in idle halt");

    // disable freezes the counter
    a_disable_stop: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_q.watchdog_disable && !mode_wr && !restart_ok |=> $stable(cnt_q))
        else $error("counter ran while disabled");

    // the error flag rises only after an early restart
    a_err_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(stat_q.window_error_flag) |-> $past(restart_bad))
        else $error("error flag without cause");

    // the underflow flag rises only after an underflow
    a_unf_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(stat_q.underflow_flag) |-> $past(underflow))
        else $error("underflow flag without cause");

    // the fault line rises only for an enabled underflow or an early restart
    a_fault_cause: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(o_fault) |-> $past(restart_bad)
        || ($past(underflow) && $past(mode_q.fault_reset_enable)))
        else $error("fault without cause");

    // a status read with no new event drops the interrupt
    a_irq_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_status_clear |=> !o_irq)
        else $error("interrupt not cleared");

    // a mode write restarts the prescaler
    a_mode_prescale: assert property (@(posedge i_core_clk) disable iff (i_reset)
        mode_wr |=> pre_q == '0)
        else $error("prescaler kept after mode write");

    // an unkeyed control write never raises the fault line
    a_unkeyed_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_wr && (i_addr == WWDT_OFS_CTRL) && (i_wdata[WWDT_KEY_LSB +: 8] != WWDT_KEY)
        && !underflow && !o_fault |=> !o_fault)
        else $error("unkeyed write raised fault");
endmodule // wwdt_top

// *** tb/testbench.sv ***
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module testbench;
    import wwdt_pkg::*;
    logic clk, rst_q, slow, slow_en, dbg, idle, wr, rd, mdl_en, mdl_rst, irq, fault, proc, mdl_proc;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d, m;
    integer seed = 83, errors = 0, num_checks = 0, cycles = 0, rises = 0, sdiv = 0, i, n;
    wire rst_w = rst_q | mdl_rst;

    wwdt_top u_dut (.i_core_clk(clk), .i_reset(rst_w), .i_slow_clk(slow), .i_debug_state(dbg),
        .i_idle_mode(idle), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_irq(irq), .o_fault(fault), .o_proc_only(proc));
    wwdt_rstc_model u_rstc (.i_core_clk(clk), .i_enable(mdl_en), .i_fault(fault),
        .i_proc_only(proc), .o_reset(mdl_rst), .o_proc_seen(mdl_proc));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // slow clock of ten core cycles, stopped when not needed; also the run ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            end_of_test();
        end
        sdiv <= (slow_en && sdiv < 4) ? sdiv + 1 : 0;
        if (slow_en && sdiv == 4) begin
            slow <= ~slow;
            rises <= rises + !slow;
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic do_reset();
        rst_q <= 1'b1;
        repeat (12) @(posedge clk);
        rst_q <= 1'b0;
    endtask

    // runs the slow clock for k rises or, with stop set, until a fault shows
    task automatic run(input integer k, input logic stop);
        integer t;
        t = rises;
        slow_en <= 1'b1;
        while (rises - t < k && !(stop && fault)) @(posedge clk);
        slow_en <= 1'b0;
        n = rises - t;
    endtask

    function automatic logic [31:0] mode_val(input logic [11:0] ld, input logic [3:0] fl,
        input logic [1:0] hl, input logic [11:0] win);
        return {2'h0, hl, win, fl, ld};
    endfunction

    initial begin
        {rst_q, slow, slow_en, dbg, idle, wr, rd, mdl_en} = 8'h80;
        {addr, wdata} = '0;
        do_reset();
        bus(0, WWDT_OFS_MODE, 0);
        check("mode reset", d, WWDT_MODE_RST);
        check("proc only", {31'h0, proc}, {31'h0, WWDT_MODE_RST[14]});
        bus(0, 4'hc, 0);
        check("unmapped", d, 32'h0);
        bus(1, WWDT_OFS_CTRL, 32'ha5000001);
        bus(0, WWDT_OFS_STAT, 0);
        check("default window", d, 32'h0);
        $display("defaults done");
        m = mode_val(12'h2, 4'b0011, 2'b00, 12'h0);
        bus(1, WWDT_OFS_MODE, m);
        bus(1, WWDT_OFS_MODE, $random(seed));
        bus(0, WWDT_OFS_MODE, 0);
        check("mode once", d, m);
        for (i = 0; i < 4; i++) begin
            m = $random(seed) | 32'h1;
            m[31:24] = (m[31:24] == WWDT_KEY) ? 8'h5a : m[31:24];
            bus(1, WWDT_OFS_CTRL, m);
        end
        bus(0, WWDT_OFS_STAT, 0);
        check("bad key", d, 32'h0);
        bus(1, WWDT_OFS_CTRL, 32'ha5000001);
        check("window fault", {30'h0, irq, fault}, 32'h3);
        bus(0, WWDT_OFS_STAT, 0);
        check("window flag", d, 32'h2);
        check("read clears", {30'h0, irq, fault}, 32'h0);
        $display("window done");
        run(500, 1);
        check("ticks to underflow", n, 3 * WWDT_PRE_DIV);
        check("kind of reset", {31'h0, mdl_proc}, 32'h0);
        bus(0, WWDT_OFS_STAT, 0);
        check("underflow flag", d, 32'h1);
        mdl_en <= 1'b1;
        bus(1, WWDT_OFS_CTRL, 32'ha5000001);
        repeat (4) @(posedge clk);
        mdl_en <= 1'b0;
        bus(0, WWDT_OFS_MODE, 0);
        check("fault reset", d, WWDT_MODE_RST);
        $display("underflow done");
        for (i = 0; i < 3; i++) begin
            do_reset();
            bus(1, WWDT_OFS_MODE, mode_val(12'h1, {i == 2, i == 1, 2'b10}, 2'b1 << i,
                i == 2 ? 0 : 12'hfff));
            {idle, dbg} <= 2'b1 << i;
            repeat (5) @(posedge clk);
            run(300, 1);
            check("halted", {31'h0, fault}, 32'h0);
            check("proc only kind", {31'h0, proc}, {31'h0, i == 1});
            {idle, dbg} <= 2'b00;
            repeat (5) @(posedge clk);
            if (i == 2) bus(1, WWDT_OFS_CTRL, 32'ha5000001);
            else run(300, 1);
            check("resumed", {30'h0, irq, fault}, 32'h1);
        end
        $display("halts done");
        end_of_test();
    end
endmodule // testbench

// *** tb/wwdt_rstc_model.sv ***
// reset controller model that answers the watchdog fault request
`timescale 1ns/1ps
module wwdt_rstc_model (
    input wire logic i_core_clk, // core clock
    input wire logic i_enable, // answer faults with a reset
    input wire logic i_fault, // fault request from the watchdog
    input wire logic i_proc_only, // fault asks processor reset only
    output logic o_reset, // reset back to the watchdog
    output logic o_proc_seen // kind of the last fault seen
);
    // one-cycle reset per fault; the pulse drops itself so a stuck fault cannot lock us up
    always_ff @(posedge i_core_clk) begin
        o_reset <= i_enable && i_fault && !o_reset;
        if (i_fault) begin
            o_proc_seen <= i_proc_only;
        end
    end
endmodule // wwdt_rstc_model
